// ===== rtl/sbtc_timer.sv
`timescale 1ns/1ps
module sbtc_timer
  import sbtc_pkg::*;
#(
  parameter int INSTR_DIV = SBTC_INSTR_DIV
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [SBTC_AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [SBTC_AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [SBTC_AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [SBTC_AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       osc_out_ext_clock_pin,
  input  wire logic [1:0]                 port_direction,
  output logic [1:0]                      osc_pin_oe_n,
  output logic                            low_power_osc_enable,
  input  wire logic                       capture_reset,
  output logic                            capture_valid,
  output logic [15:0]                     count_value,
  output logic                            irq
);

  generate
    if (INSTR_DIV < 1 || INSTR_DIV > (1 << SBTC_DIV_W)) begin : g_chk
      $error("INSTR_DIV must lie between 1 and 256.");
    end
  endgenerate

  // The register map needs offsets up to 0x10 and one 8-bit data lane.
  // A narrower bus could not reach the control register.
  generate
    if (SBTC_AXI_ADDR_W < 5 || SBTC_AXI_DATA_W < 8) begin : g_bus_chk
      $error("Register bus too narrow for the register map.");
    end
  endgenerate

  // Last divider state; the instruction tick is raised while it stands.
  // A ratio of one keeps the tick high on every clock.
  localparam logic [SBTC_DIV_W-1:0] DIV_LAST = SBTC_DIV_W'(INSTR_DIV - 1);

  // All state lives in one struct: q holds the registers and d their
  // next value, filled by a single combinational process.
  sbtc_state_t q;
  sbtc_state_t d;

  logic       run;
  logic       ext_src;
  logic       no_sync;
  logic [1:0] ps_sel;
  logic [2:0] ps_last;
  logic       src_tick;
  logic       ps_tick;
  logic       inc;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       do_write;
  logic       ovf_set;
  logic       ovf_clr;
  logic [7:0] rd_byte;
  logic       rd_hit;
  logic       wr_low;
  logic       wr_high;
  logic       wr_mask;
  logic       wr_ctrl;
  logic       wr_miss;
  logic       count_wr;
  logic [15:0] count_base;

  assign run     = q.ctrl[SBTC_CTL_RUN];
  assign ext_src = q.ctrl[SBTC_CTL_SRC];
  assign no_sync = q.ctrl[SBTC_CTL_NSYNC];
  assign ps_sel  = q.ctrl[SBTC_CTL_PS_LO +: 2];
  // Last prescaler state for the ratios 1, 2, 4 and 8.
  assign ps_last = 3'((4'h1 << ps_sel) - 4'h1);

  // Each write channel is refused while its own half is parked or while
  // the previous answer waits, so a write never overruns an unread
  // response and the two halves may arrive in either order.
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready  = !q.w_have && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign do_write      = q.aw_have && q.w_have;

  // The read mux decodes the live address, so the data are caught in the
  // answer register at the edge that takes the request.
  // Unmapped offsets read zero and answer with a slave error.
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr)
      SBTC_OFF_LOW:     rd_byte = q.count[7:0];
      SBTC_OFF_HIGH:    rd_byte = q.count[15:8];
      SBTC_OFF_STATUS:  rd_byte = {7'h00, q.ovf_sts};
      SBTC_OFF_MASK:    rd_byte = {7'h00, q.ovf_mask};
      SBTC_OFF_CONTROL: rd_byte = {2'h0, q.ctrl};
      default:          rd_hit  = 1'b0;
    endcase
  end

  // Instruction cycle tick or a synchronised rising edge on the pin.
  // The pin always passes the two-stage synchroniser, even in the
  // asynchronous mode: this block has one clock, so that mode only
  // skips the extra sample after the prescaler.
  always_comb begin
    if (ext_src) begin
      src_tick = q.ext_s2 && !q.ext_prev;
    end else begin
      src_tick = (q.div_cnt == DIV_LAST);
    end
    // The prescaler emits one tick per full ratio of source events.
    ps_tick = run && src_tick && (q.ps_cnt == ps_last);
    if (ext_src && !no_sync) begin
      inc = q.sync_tick;
    end else begin
      inc = ps_tick;
    end
    inc = inc && run;
  end

  // A count write or a capture clear in the same cycle replaces the
  // increment, so no rollover happens and none may be flagged.
  assign ovf_set = inc && (q.count == SBTC_COUNT_MAX) &&
                   !count_wr && !capture_reset;
  assign ovf_clr = ar_take && (s_axi_araddr == SBTC_OFF_STATUS);

  // Decode the parked write once; only byte lane 0 carries data.
  always_comb begin
    wr_low  = 1'b0;
    wr_high = 1'b0;
    wr_mask = 1'b0;
    wr_ctrl = 1'b0;
    wr_miss = 1'b0;
    case (q.aw_addr)
      SBTC_OFF_LOW: begin
        wr_low = do_write && q.w_lane0;
      end
      SBTC_OFF_HIGH: begin
        wr_high = do_write && q.w_lane0;
      end
      SBTC_OFF_STATUS: begin
      end
      SBTC_OFF_MASK: begin
        wr_mask = do_write && q.w_lane0;
      end
      SBTC_OFF_CONTROL: begin
        wr_ctrl = do_write && q.w_lane0;
      end
      default: begin
        wr_miss = do_write;
      end
    endcase
  end

  // The byte not written keeps its old value, or zero under a capture clear,
  // rather than the increment, so a write to one half never carries into the other half.
  assign count_wr   = wr_low || wr_high;
  assign count_base = capture_reset ? SBTC_COUNT_RESET : q.count;

  always_comb begin
    d = q;

    // Two flip-flops before any use of the pin, then a delayed copy for
    // the rising-edge detector; all rest low like the idle pin.
    d.ext_s1   = osc_out_ext_clock_pin;
    d.ext_s2   = q.ext_s1;
    d.ext_prev = q.ext_s2;

    // The divider runs freely so the instruction tick keeps its phase
    // while the counter is halted.
    if (q.div_cnt == DIV_LAST) begin
      d.div_cnt = '0;
    end else begin
      d.div_cnt = q.div_cnt + 1'b1;
    end

    // The prescaler only moves while running, so halting freezes it
    // together with the count.
    if (run && src_tick) begin
      if (q.ps_cnt >= ps_last) begin
        d.ps_cnt = 3'h0;
      end else begin
        d.ps_cnt = q.ps_cnt + 3'h1;
      end
    end
    // Synchronous mode spends one more clock sampling the prescaled edge.
    d.sync_tick = ps_tick && ext_src && !no_sync;

    if (inc) begin
      d.count = q.count + 16'h0001;
    end
    // Capture clear beats the increment; a register write beats both in the byte it writes.
    if (capture_reset) begin
      d.count = SBTC_COUNT_RESET;
    end

    // Address and data park separately until both halves have arrived.
    if (aw_take) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      d.w_have  = 1'b1;
      d.w_data  = s_axi_wdata[7:0];
      d.w_lane0 = s_axi_wstrb[0];
    end
    // The write answer drops at the edge where the master takes it.
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // The answer goes out together with the register effect.
    if (do_write) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_miss ? SBTC_RESP_SLVERR : SBTC_RESP_OKAY;
    end
    // A count write restarts the prescaler and overrides the increment.
    if (count_wr) begin
      d.ps_cnt = 3'h0;
    end
    if (wr_low) begin
      d.count = {count_base[15:8], q.w_data};
    end
    if (wr_high) begin
      d.count = {q.w_data, count_base[7:0]};
    end
    if (wr_mask) begin
      d.ovf_mask = q.w_data[0];
    end
    if (wr_ctrl) begin
      d.ctrl = q.w_data[SBTC_CTL_W-1:0];
    end

    // A new read takes precedence; arready is low while an answer
    // stands, so the two branches never meet.
    if (ar_take) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_byte;
      d.rresp  = rd_hit ? SBTC_RESP_OKAY : SBTC_RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // A read of the status clears it, but a new overflow wins.
    if (ovf_clr) begin
      d.ovf_sts = 1'b0;
    end
    if (ovf_set) begin
      d.ovf_sts = 1'b1;
    end
  end

  // Reset loads constants only; the control word clears, so the counter
  // starts halted on the instruction clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q.aw_have   <= 1'b0;
      q.aw_addr   <= 8'h00;
      q.w_have    <= 1'b0;
      q.w_data    <= 8'h00;
      q.w_lane0   <= 1'b0;
      q.bvalid    <= 1'b0;
      q.bresp     <= SBTC_RESP_OKAY;
      q.rvalid    <= 1'b0;
      q.rdata     <= 8'h00;
      q.rresp     <= SBTC_RESP_OKAY;
      q.ctrl      <= SBTC_CTL_RESET;
      q.count     <= SBTC_COUNT_RESET;
      q.ovf_sts   <= 1'b0;
      q.ovf_mask  <= 1'b0;
      q.ext_s1    <= 1'b0;
      q.ext_s2    <= 1'b0;
      q.ext_prev  <= 1'b0;
      q.div_cnt   <= '0;
      q.ps_cnt    <= 3'h0;
      q.sync_tick <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Oscillator pins give up their drivers while the oscillator runs.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      assign osc_pin_oe_n[gi] = q.ctrl[SBTC_CTL_OSC] | port_direction[gi];
    end
  endgenerate

  // Bit 3 powers the oscillator and frees both pins; it does not gate the count.
  assign low_power_osc_enable = q.ctrl[SBTC_CTL_OSC];
  // Capture is untrustworthy only when the pin drives the count without the
  // extra sample; this flag tells the capture unit so.
  assign capture_valid        = !(ext_src && no_sync);
  assign count_value          = q.count;
  // The interrupt is a level that follows the sticky status and mask.
  assign irq                  = q.ovf_sts && q.ovf_mask;

  // Answers come straight from registers, so they stand unchanged
  // until the master takes them.
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp  = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata  = {24'h000000, q.rdata};
  assign s_axi_rresp  = q.rresp;

endmodule

// ===== rtl/sbtc_pkg.sv
package sbtc_pkg;

  localparam int          SBTC_AXI_ADDR_W   = 8;
  localparam int          SBTC_AXI_DATA_W   = 32;

  localparam logic [7:0]  SBTC_OFF_LOW      = 8'h00;
  localparam logic [7:0]  SBTC_OFF_HIGH     = 8'h04;
  localparam logic [7:0]  SBTC_OFF_STATUS   = 8'h08;
  localparam logic [7:0]  SBTC_OFF_MASK     = 8'h0C;
  localparam logic [7:0]  SBTC_OFF_CONTROL  = 8'h10;

  localparam int          SBTC_CTL_RUN      = 0;
  localparam int          SBTC_CTL_SRC      = 1;
  localparam int          SBTC_CTL_NSYNC    = 2;
  localparam int          SBTC_CTL_OSC      = 3;
  localparam int          SBTC_CTL_PS_LO    = 4;
  localparam int          SBTC_CTL_W        = 6;

  localparam logic [5:0]  SBTC_CTL_RESET    = 6'h00;
  localparam logic [15:0] SBTC_COUNT_RESET  = 16'h0000;
  localparam logic [15:0] SBTC_COUNT_MAX    = 16'hFFFF;
  localparam logic [1:0]  SBTC_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  SBTC_RESP_SLVERR  = 2'h2;

  localparam int          SBTC_INSTR_DIV    = 4;
  localparam int          SBTC_DIV_W        = 8;

  typedef struct packed {
    logic                  aw_have;
    logic [7:0]            aw_addr;
    logic                  w_have;
    logic [7:0]            w_data;
    logic                  w_lane0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [7:0]            rdata;
    logic [1:0]            rresp;
    logic [SBTC_CTL_W-1:0] ctrl;
    logic [15:0]           count;
    logic                  ovf_sts;
    logic                  ovf_mask;
    logic                  ext_s1;
    logic                  ext_s2;
    logic                  ext_prev;
    logic [SBTC_DIV_W-1:0] div_cnt;
    logic [2:0]            ps_cnt;
    logic                  sync_tick;
  } sbtc_state_t;

endpackage

// ===== tb/sbtc_props.sv
`timescale 1ns/1ps
module sbtc_props
  import sbtc_pkg::*;
(
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [SBTC_AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic [1:0]                 port_direction,
  input wire logic [1:0]                 osc_pin_oe_n,
  input wire logic                       low_power_osc_enable,
  input wire logic                       capture_reset,
  input wire logic [15:0]                count_value,
  input wire logic                       irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
    else $error("write answer not on time");
  AST_RD_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer not on time");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_OSC_PINS: assert property (low_power_osc_enable |-> osc_pin_oe_n == 2'h3)
    else $error("oscillator pins not inputs");
  AST_PORT_PINS: assert property (!low_power_osc_enable |-> osc_pin_oe_n == port_direction)
    else $error("pin enables differ from port direction");
  AST_CAP_CLEAR: assert property (capture_reset |=> count_value == 16'h0 || $rose(s_axi_bvalid))
    else $error("capture reset did not clear count");
  AST_STEP: assert property ((count_value != $past(count_value)) && !$rose(s_axi_bvalid) && !$past(capture_reset) |-> count_value == $past(count_value) + 16'h1)
    else $error("count moved by other than one");
  AST_IRQ_RISE: assert property ($rose(irq) |-> $rose(s_axi_bvalid) || (count_value == 16'h0 && $past(count_value) == 16'hFFFF))
    else $error("interrupt rose without overflow");
  AST_IRQ_STICKY: assert property ($fell(irq) |-> s_axi_rvalid || $past(s_axi_rvalid) || $rose(s_axi_bvalid))
    else $error("interrupt dropped without access");
endmodule
bind sbtc_timer sbtc_props u_props (.*);

// ===== tb/sbtc_ext_src.sv
`timescale 1ns/1ps
module sbtc_ext_src (
  input  wire logic aclk,
  output logic      pin
);
  // The pin rests low between bursts, so no stray rising edge is seen.
  initial pin = 1'b0;
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge aclk);
      pin <= 1'b1;
      repeat (w) @(posedge aclk);
      pin <= 1'b0;
      repeat (w) @(posedge aclk);
    end
  endtask
endmodule

// ===== tb/tb_sbtc_timer.sv
`timescale 1ns/1ps
module tb_sbtc_timer
  import sbtc_pkg::*;
;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, port_direction, osc_pin_oe_n, rsp;
  logic [15:0] count_value;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, irq, capture_reset;
  logic        osc_out_ext_clock_pin, low_power_osc_enable, capture_valid;
  logic        ta, tw;
  int          bad_count = 0, cmp_count = 0, cyc = 0, n, i;
  sbtc_timer #(.INSTR_DIV(4)) u_dut (.*);
  sbtc_ext_src u_src (.aclk(aclk), .pin(osc_out_ext_clock_pin));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do begin
      @(negedge aclk);
      ta = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
    end while (!ta);
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      @(posedge aclk);
    end while (!ta);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      ta = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
    end while (!ta);
    s_axi_rready <= 1'b0;
    @(negedge aclk);
  endtask
  // Cycles between two count steps, skipping the first partial one.
  task automatic gap(output int g);
    logic [15:0] v;
    @(negedge aclk);
    v = count_value;
    while (count_value === v) @(negedge aclk);
    v = count_value;
    g = 0;
    while (count_value === v) begin
      @(negedge aclk);
      g++;
    end
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, capture_reset, aresetn} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    port_direction = 2'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SBTC_OFF_CONTROL);
    chk(d, 32'h0);
    chk({29'h0, low_power_osc_enable, capture_valid, irq}, 32'h2);
    wr(SBTC_OFF_CONTROL, 32'hFF);
    rd(SBTC_OFF_CONTROL);
    chk(d, 32'h3F);
    chk({29'h0, low_power_osc_enable, osc_pin_oe_n}, 32'h7);
    @(posedge aclk);
    port_direction <= 2'h1;
    wr(SBTC_OFF_CONTROL, 32'h0);
    chk({29'h0, low_power_osc_enable, osc_pin_oe_n}, 32'h1);
    wr(SBTC_OFF_LOW, 32'h34);
    wr(SBTC_OFF_HIGH, 32'h12);
    rd(SBTC_OFF_LOW);
    chk(d, 32'h34);
    rd(SBTC_OFF_HIGH);
    chk(d, 32'h12);
    rd(8'h14);
    chk({rsp, d[29:0]}, {SBTC_RESP_SLVERR, 30'h0});
    wr(8'h14, 32'h1);
    chk(32'(rsp), 32'(SBTC_RESP_SLVERR));
    for (i = 0; i < 4; i++) begin
      wr(SBTC_OFF_CONTROL, 32'(i * 16 + 1));
      gap(n);
      chk(32'(n), 32'(4 << i));
    end
    wr(SBTC_OFF_CONTROL, 32'h0);
    d = {16'h0, count_value};
    repeat (20) @(negedge aclk);
    chk({16'h0, count_value}, d);
    wr(SBTC_OFF_HIGH, 32'hFF);
    wr(SBTC_OFF_LOW, 32'hF0);
    wr(SBTC_OFF_CONTROL, 32'h1);
    while (count_value[15:8] !== 8'h00) @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(SBTC_OFF_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(SBTC_OFF_STATUS);
    chk({d[30:0], irq}, 32'h2);
    rd(SBTC_OFF_STATUS);
    chk({31'h0, count_value != 16'h0}, {d[30:0], 1'b1});
    wr(SBTC_OFF_CONTROL, 32'h0);
    @(posedge aclk);
    capture_reset <= 1'b1;
    @(posedge aclk);
    capture_reset <= 1'b0;
    @(negedge aclk);
    chk({16'h0, count_value}, 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(SBTC_OFF_LOW, 32'h0);
      wr(SBTC_OFF_CONTROL, 32'(3 + 4 * i));
      chk({31'h0, capture_valid}, 32'(1 - i));
      u_src.pulses(3, 2 + 3 * i);
      repeat (8) @(negedge aclk);
      chk({16'h0, count_value}, 32'h3);
      wr(SBTC_OFF_CONTROL, 32'h0);
    end
    wr(SBTC_OFF_CONTROL, 32'h5);
    gap(n);
    chk({31'(n), capture_valid}, 32'h9);
    give_verdict();
  end
endmodule
